// File: verilog/crcg_pkg.sv
// crcg_pkg: register map, field positions and reset values of the programmable crc generator.
// assumes a 32-bit axi4-lite register bus with one aligned word per register.
`default_nettype none

package crcg_pkg;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [3:0] OFS_CTRL  = 4'h0;
	localparam logic [3:0] OFS_TAP   = 4'h4;
	localparam logic [3:0] OFS_DATA  = 4'h8;
	localparam logic [3:0] OFS_WDATA = 4'hC;

	// ----------------------------------------------------------------
	// crc_control fields
	// ----------------------------------------------------------------
	localparam int CTL_POLY_LENGTH_LSB  = 0;
	localparam int CTL_GO_BIT    = 4;
	localparam int CTL_EMPTY_BIT = 6;
	localparam int CTL_FULL_BIT  = 7;
	localparam int CTL_CNT_LSB   = 8;
	localparam int CTL_IDLE_BIT  = 13;

	// ----------------------------------------------------------------
	// reset values and limits
	// ----------------------------------------------------------------
	localparam logic [3:0]  RST_POLY_LENGTH     = 4'h0;
	localparam logic        RST_GO       = 1'b0;
	localparam logic        RST_IDLE     = 1'b0;
	localparam logic [15:0] RST_TAP      = 16'h0000;
	localparam logic [15:0] RST_CRC      = 16'h0000;
	localparam logic [3:0]  POLY_LENGTH_NARROW  = 4'h7;
	localparam logic [4:0]  DEPTH_WIDE   = 5'h08;
	localparam logic [4:0]  DEPTH_NARROW = 5'h10;

	// ----------------------------------------------------------------
	// axi responses
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage : crcg_pkg

`default_nettype wire

// File: verilog/crcg_fifo_mem.sv
// crcg_fifo_mem: storage of the crc data fifo, one write and one registered read port.
// assumes the caller keeps its own pointers; a read of the address being written returns the new word.
`default_nettype none

module crcg_fifo_mem #(
	parameter int W  = 16,
	parameter int D  = 16,
	parameter int AW = 4
) (
	input  wire logic          clk,
	input  wire logic          rstn,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [W-1:0]  wr_data,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [W-1:0]  rd_data
);

	if (D > (1 << AW)) begin : g_chk
		$error("crcg_fifo_mem: depth does not fit the address width");
	end

	logic [W-1:0] mem [D];
	logic [W-1:0] nxt_rd;
	logic [W-1:0] rd_ff;

	// write-first bypass so a word pushed into an empty fifo is shiftable next cycle
	always_comb begin
		nxt_rd = (wr_en && wr_addr == rd_addr) ? wr_data : mem[rd_addr];
	end

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rd_ff <= '0;
		end else begin
			rd_ff <= nxt_rd;
		end
	end

	assign rd_data = rd_ff;

endmodule : crcg_fifo_mem

`default_nettype wire

// File: verilog/crcg_top.sv
// crcg_top: programmable crc generator with data fifo, serial shifter and axi4-lite registers.
// assumes sleep_req and idle_req come from power logic on clk; crc_event goes to an interrupt controller.
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`default_nettype none

module crcg_top #(
	parameter int ADDR_W = 4
) (
	input  wire logic              clk,
	input  wire logic              rstn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              sleep_req,
	input  wire logic              idle_req,
	output logic                   crc_event
);

	if (ADDR_W < 4) begin : g_chk
		$error("crcg_top: address width too small for the register map");
	end

	// ----------------------------------------------------------------
	// register bus, write side
	// ----------------------------------------------------------------
	logic              aw_hold_ff, nxt_aw_hold;
	logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
	logic              w_hold_ff, nxt_w_hold;
	logic [31:0]       wdata_ff, nxt_wdata;
	logic [3:0]        wstrb_ff, nxt_wstrb;
	logic              bvalid_ff, nxt_bvalid;
	logic [1:0]        bresp_ff, nxt_bresp;
	logic              do_wr;
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0]       wr_data;
	logic [3:0]        wr_strb;
	logic              wr_ctrl, wr_tap, wr_crc, wr_wdat;

	assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
	assign s_axi_wready  = !w_hold_ff && !bvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;

	always_comb begin
		do_wr   = (aw_hold_ff || s_axi_awvalid) && (w_hold_ff || s_axi_wvalid) && !bvalid_ff;
		wr_addr = aw_hold_ff ? awaddr_ff : s_axi_awaddr;
		wr_data = w_hold_ff ? wdata_ff : s_axi_wdata;
		wr_strb = w_hold_ff ? wstrb_ff : s_axi_wstrb;
		wr_ctrl = 1'b0;
		wr_tap  = 1'b0;
		wr_crc  = 1'b0;
		wr_wdat = 1'b0;
		if (wr_addr == ADDR_W'(crcg_pkg::OFS_CTRL)) begin
			wr_ctrl = do_wr;
		end else if (wr_addr == ADDR_W'(crcg_pkg::OFS_TAP)) begin
			wr_tap = do_wr;
		end else if (wr_addr == ADDR_W'(crcg_pkg::OFS_DATA)) begin
			wr_crc = do_wr;
		end else if (wr_addr == ADDR_W'(crcg_pkg::OFS_WDATA)) begin
			wr_wdat = do_wr;
		end
		nxt_aw_hold = aw_hold_ff;
		nxt_awaddr  = awaddr_ff;
		nxt_w_hold  = w_hold_ff;
		nxt_wdata   = wdata_ff;
		nxt_wstrb   = wstrb_ff;
		nxt_bvalid  = bvalid_ff && !s_axi_bready;
		nxt_bresp   = bresp_ff;
		if (do_wr) begin
			nxt_aw_hold = 1'b0;
			nxt_w_hold  = 1'b0;
			nxt_bvalid  = 1'b1;
			nxt_bresp   = (wr_ctrl || wr_tap || wr_crc || wr_wdat) ? crcg_pkg::RESP_OKAY : crcg_pkg::RESP_DECERR;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				nxt_aw_hold = 1'b1;
				nxt_awaddr  = s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				nxt_w_hold = 1'b1;
				nxt_wdata  = s_axi_wdata;
				nxt_wstrb  = s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			aw_hold_ff <= 1'b0;
			awaddr_ff  <= '0;
			w_hold_ff  <= 1'b0;
			wdata_ff   <= 32'h0000_0000;
			wstrb_ff   <= 4'h0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= crcg_pkg::RESP_OKAY;
		end else begin
			aw_hold_ff <= nxt_aw_hold;
			awaddr_ff  <= nxt_awaddr;
			w_hold_ff  <= nxt_w_hold;
			wdata_ff   <= nxt_wdata;
			wstrb_ff   <= nxt_wstrb;
			bvalid_ff  <= nxt_bvalid;
			bresp_ff   <= nxt_bresp;
		end
	end

	// ----------------------------------------------------------------
	// configuration, fifo bookkeeping and crc engine
	// ----------------------------------------------------------------
	logic [3:0]  poly_length_ff, nxt_poly_length;
	logic        go_ff, nxt_go;
	logic        idle_stop_ff, nxt_idle_stop;
	logic [15:0] tap_ff, nxt_tap;
	logic [15:0] crc_ff, nxt_crc;
	logic [4:0]  count_ff, nxt_count;
	logic [3:0]  wr_ptr_ff, nxt_wr_ptr;
	logic [3:0]  rd_ptr_ff, nxt_rd_ptr;
	logic [3:0]  pos_ff, nxt_pos;
	logic [7:0]  low_hold_ff, nxt_low_hold;
	logic        event_ff, nxt_event;
	logic [4:0]  depth;
	logic        fifo_full_flag, fifo_empty_flag;
	logic        frozen, shift_en, push_req, push, wrap, pop;
	logic [15:0] push_data, head_data, crc_shift, tap_full;
	logic        din, fb;

	// the deeper fifo serves byte-wide elements, the shallow one wider elements
	assign depth           = (poly_length_ff > crcg_pkg::POLY_LENGTH_NARROW) ? crcg_pkg::DEPTH_WIDE : crcg_pkg::DEPTH_NARROW;
	assign fifo_full_flag  = (count_ff == depth);
	assign fifo_empty_flag = (count_ff == 5'h00);
	// sleep, or idle with idle-stop set, holds every config, fifo and crc register; the bus handshake registers still run
	assign frozen   = sleep_req || (idle_req && idle_stop_ff);
	assign shift_en = go_ff && !fifo_empty_flag && !frozen;
	assign pop      = shift_en && (pos_ff == poly_length_ff);
	assign din      = head_data[poly_length_ff - pos_ff];
	assign fb       = crc_ff[poly_length_ff] ^ din;
	assign tap_full = {tap_ff[15:1], 1'b1};

	genvar g;
	for (g = 0; g < 16; g++) begin : g_crc
		if (g == 0) begin : g_lo
			assign crc_shift[g] = fb & tap_full[g];
		end else begin : g_hi
			// bits above the programmed length stay zero, so x^(poly_length+1) is the implied top term
			assign crc_shift[g] = (g <= poly_length_ff) ? (crc_ff[g-1] ^ (fb & tap_full[g])) : 1'b0;
		end
	end

	// a wide element is pushed by the write that carries its upper byte
	always_comb begin
		push_req  = 1'b0;
		push_data = 16'h0000;
		nxt_low_hold = low_hold_ff;
		if (wr_wdat && !frozen) begin
			if (poly_length_ff <= crcg_pkg::POLY_LENGTH_NARROW) begin
				push_req  = wr_strb[0];
				push_data = {8'h00, wr_data[7:0]};
			end else if (wr_strb[1]) begin
				push_req  = 1'b1;
				push_data = {wr_data[15:8], wr_strb[0] ? wr_data[7:0] : low_hold_ff};
			end else if (wr_strb[0]) begin
				nxt_low_hold = wr_data[7:0];
			end
		end
		wrap = push_req && fifo_full_flag;
		push = push_req && !fifo_full_flag;
	end

	always_comb begin
		nxt_poly_length      = poly_length_ff;
		nxt_go        = go_ff;
		nxt_idle_stop = idle_stop_ff;
		nxt_tap       = tap_ff;
		if (wr_ctrl && !frozen) begin
			if (wr_strb[0]) begin
				nxt_poly_length = wr_data[crcg_pkg::CTL_POLY_LENGTH_LSB +: 4];
				nxt_go   = wr_data[crcg_pkg::CTL_GO_BIT];
			end
			if (wr_strb[1]) begin
				nxt_idle_stop = wr_data[crcg_pkg::CTL_IDLE_BIT];
			end
		end
		if (wr_tap && !frozen) begin
			if (wr_strb[0]) nxt_tap[7:1] = wr_data[7:1];
			if (wr_strb[1]) nxt_tap[15:8] = wr_data[15:8];
		end
		nxt_crc = shift_en ? crc_shift : crc_ff;
		if (wr_crc && !frozen) begin
			if (wr_strb[0]) nxt_crc[7:0] = wr_data[7:0];
			if (wr_strb[1]) nxt_crc[15:8] = wr_data[15:8];
		end
		nxt_wr_ptr = wr_ptr_ff;
		nxt_rd_ptr = rd_ptr_ff;
		nxt_count  = count_ff;
		nxt_pos    = shift_en ? (pop ? 4'h0 : pos_ff + 4'h1) : pos_ff;
		if (wrap) begin
			nxt_wr_ptr = 4'h0;
			nxt_rd_ptr = 4'h0;
			nxt_count  = 5'h00;
			nxt_pos    = 4'h0;
		end else begin
			if (push) begin
				nxt_wr_ptr = (depth == crcg_pkg::DEPTH_WIDE) ? {1'b0, wr_ptr_ff[2:0] + 3'h1} : wr_ptr_ff + 4'h1;
			end
			if (pop) begin
				nxt_rd_ptr = (depth == crcg_pkg::DEPTH_WIDE) ? {1'b0, rd_ptr_ff[2:0] + 3'h1} : rd_ptr_ff + 4'h1;
			end
			nxt_count = count_ff + (push ? 5'h01 : 5'h00) - (pop ? 5'h01 : 5'h00);
		end
		// a wrap lands on zero from full, never from one, so it raises no event
		nxt_event = (count_ff == 5'h01) && (nxt_count == 5'h00) && !wrap;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			poly_length_ff      <= crcg_pkg::RST_POLY_LENGTH;
			go_ff        <= crcg_pkg::RST_GO;
			idle_stop_ff <= crcg_pkg::RST_IDLE;
			tap_ff       <= crcg_pkg::RST_TAP;
			crc_ff       <= crcg_pkg::RST_CRC;
			count_ff     <= 5'h00;
			wr_ptr_ff    <= 4'h0;
			rd_ptr_ff    <= 4'h0;
			pos_ff       <= 4'h0;
			low_hold_ff  <= 8'h00;
			event_ff     <= 1'b0;
		end else begin
			poly_length_ff      <= nxt_poly_length;
			go_ff        <= nxt_go;
			idle_stop_ff <= nxt_idle_stop;
			tap_ff       <= nxt_tap;
			crc_ff       <= nxt_crc;
			count_ff     <= nxt_count;
			wr_ptr_ff    <= nxt_wr_ptr;
			rd_ptr_ff    <= nxt_rd_ptr;
			pos_ff       <= nxt_pos;
			low_hold_ff  <= nxt_low_hold;
			event_ff     <= nxt_event;
		end
	end

	assign crc_event = event_ff;

	crcg_fifo_mem #(
		.W  (16),
		.D  (16),
		.AW (4)
	) u_mem (
		.clk     (clk),
		.rstn    (rstn),
		.wr_en   (push),
		.wr_addr (wr_ptr_ff),
		.wr_data (push_data),
		.rd_addr (nxt_rd_ptr),
		.rd_data (head_data)
	);

	// ----------------------------------------------------------------
	// register bus, read side
	// ----------------------------------------------------------------
	logic        rvalid_ff, nxt_rvalid;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [1:0]  rresp_ff, nxt_rresp;
	logic [15:0] ctrl_view;

	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;
	assign ctrl_view = {2'b00, idle_stop_ff, count_ff, fifo_full_flag, fifo_empty_flag, 1'b0, go_ff, poly_length_ff};

	always_comb begin
		nxt_rvalid = rvalid_ff && !s_axi_rready;
		nxt_rdata  = rdata_ff;
		nxt_rresp  = rresp_ff;
		if (s_axi_arvalid && s_axi_arready) begin
			nxt_rvalid = 1'b1;
			nxt_rresp  = crcg_pkg::RESP_OKAY;
			if (s_axi_araddr == ADDR_W'(crcg_pkg::OFS_CTRL)) begin
				nxt_rdata = {16'h0000, ctrl_view};
			end else if (s_axi_araddr == ADDR_W'(crcg_pkg::OFS_TAP)) begin
				nxt_rdata = {16'h0000, tap_ff[15:1], 1'b0};
			end else if (s_axi_araddr == ADDR_W'(crcg_pkg::OFS_DATA) ||
			             s_axi_araddr == ADDR_W'(crcg_pkg::OFS_WDATA)) begin
				nxt_rdata = {16'h0000, crc_ff};
			end else begin
				nxt_rdata = 32'h0000_0000;
				nxt_rresp = crcg_pkg::RESP_DECERR;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
			rresp_ff  <= crcg_pkg::RESP_OKAY;
		end else begin
			rvalid_ff <= nxt_rvalid;
			rdata_ff  <= nxt_rdata;
			rresp_ff  <= nxt_rresp;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_last_bit;
		shift_en && (pos_ff == poly_length_ff);
	endsequence
	sequence s_count_down;
		count_ff == $past(count_ff) - 5'h01;
	endsequence

	property p_halt_keeps;
		(!go_ff && !wr_crc && !wrap) |=> $stable(crc_ff) && $stable(pos_ff);
	endproperty
	a_halt_keeps: assert property (p_halt_keeps) else $error("crc changed while stopped");
	property p_wide_depth;
		(poly_length_ff > 4'h7) |-> (count_ff <= 5'h08);
	endproperty
	a_wide_depth: assert property (p_wide_depth) else $error("wide fifo over eight");
	property p_push_up;
		(push && !pop) |=> (count_ff == $past(count_ff) + 5'h01);
	endproperty
	a_push_up: assert property (p_push_up) else $error("count did not increment");
	property p_pop_down;
		(s_last_bit and !push_req) |=> s_count_down;
	endproperty
	a_pop_down: assert property (p_pop_down) else $error("count did not decrement");
	property p_no_shift;
		(count_ff == 5'h00 || !go_ff) |=> (crc_ff == $past(crc_ff)) || $past(wr_crc);
	endproperty
	a_no_shift: assert property (p_no_shift) else $error("shift without data or start");
	property p_full_flag;
		(poly_length_ff <= 4'h7 && count_ff == 5'h10) |-> ctrl_view[7] && !ctrl_view[6];
	endproperty
	a_full_flag: assert property (p_full_flag) else $error("full flag missing");
	property p_wrap;
		wrap |=> (count_ff == 5'h00) && !crc_event;
	endproperty
	a_wrap: assert property (p_wrap) else $error("wrap did not clear count or raised event");
	property p_event;
		crc_event |-> (count_ff == 5'h00) && ($past(count_ff) == 5'h01);
	endproperty
	a_event: assert property (p_event) else $error("event without one to zero");
	property p_freeze;
		(frozen && !wr_crc) |=> $stable(crc_ff) && $stable(pos_ff) && $stable(rd_ptr_ff);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while frozen");
	property p_cnt_read;
		(s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_W'(crcg_pkg::OFS_CTRL)) |=>
			(s_axi_rdata[12:8] == $past(count_ff));
	endproperty
	a_cnt_read: assert property (p_cnt_read) else $error("count field misread");

endmodule : crcg_top

`default_nettype wire

// File: dv/tb_top.sv
// tb_top: self-checking bench for the programmable crc generator, driven over axi4-lite.
// assumes crcg_top with ADDR_W widened to 5 so that byte address 0x10 is an unmapped place.
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	localparam logic [4:0] A_CTL = {1'b0, crcg_pkg::OFS_CTRL};
	localparam logic [4:0] A_TAP = {1'b0, crcg_pkg::OFS_TAP};
	localparam logic [4:0] A_DAT = {1'b0, crcg_pkg::OFS_DATA};
	localparam logic [4:0] A_WDT = {1'b0, crcg_pkg::OFS_WDATA};
	localparam logic [31:0] GO   = 32'h0000_0010;
	localparam logic [31:0] IDLE = 32'h0000_2000;

	logic        clk       = 1'b0;
	logic        rstn      = 1'b0;
	logic [4:0]  awaddr    = 5'h00;
	logic        awvalid   = 1'b0;
	logic [31:0] wdata     = 32'h0000_0000;
	logic [3:0]  wstrb     = 4'h0;
	logic        wvalid    = 1'b0;
	logic        bready    = 1'b0;
	logic [4:0]  araddr    = 5'h00;
	logic        arvalid   = 1'b0;
	logic        rready    = 1'b0;
	logic        sleep_req = 1'b0;
	logic        idle_req  = 1'b0;
	wire logic   awready, wready, bvalid, arready, rvalid, crc_event;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	int          error_cnt = 0;
	int          n_checks  = 0;
	int          cyc       = 0;
	int          ev_cnt    = 0;
	int          ev_cyc    = 0;
	int          t_b       = 0;
	logic [31:0] rd;
	logic [1:0]  rsp;

	crcg_top #(.ADDR_W(5)) u_dut (
		.clk(clk), .rstn(rstn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.sleep_req(sleep_req), .idle_req(idle_req), .crc_event(crc_event)
	);

	always #50 clk = ~clk;

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (crc_event === 1'b1) begin
			ev_cnt <= ev_cnt + 1;
			ev_cyc <= cyc;
		end
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// no cycle count is assumed here; only the watchdog ends a stuck wait
		while (bvalid !== 1'b1) begin
			@(posedge clk);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
		end
		rsp = bresp;
		t_b = cyc;
		bready <= 1'b0;
	endtask : wr

	task automatic rd_reg(input logic [4:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (rvalid !== 1'b1) begin
			@(posedge clk);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
		end
		rd = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask : rd_reg

	// galois step over one element, msb first, bits pl down to 0
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] d,
			input logic [3:0] pl, input logic [15:0] tp);
		logic [15:0] m;
		logic [15:0] p;
		logic        fb;
		m = 16'hFFFF >> (4'hF - pl);
		p = (tp & m & 16'hFFFE) | 16'h0001;
		for (int i = 15; i >= 0; i--) begin
			if (i <= int'(pl)) begin
				fb = c[pl] ^ d[i];
				c = ((c << 1) & m) ^ (fb ? p : 16'h0000);
			end
		end
		return c;
	endfunction : crc_step

	task automatic wait_ev(input int e0);
		for (int t = 0; t < 3000 && ev_cnt == e0; t++) @(posedge clk);
		repeat (4) @(posedge clk);
		chk(32'(ev_cnt - e0), 32'h0000_0001, "one event per drain");
	endtask : wait_ev

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic s_reset();
		rd_reg(A_CTL);
		chk(rd, 32'h0000_0040, "control after reset");
		rd_reg(A_TAP);
		chk(rd, 32'h0000_0000, "taps after reset");
		wr(A_TAP, 32'h0000_FFFF, 4'h3);
		rd_reg(A_TAP);
		chk(rd, 32'h0000_FFFE, "tap bit0 reads zero");
		wr(5'h10, 32'h0000_1234, 4'hF);
		chk(32'(rsp), 32'(crcg_pkg::RESP_DECERR), "unmapped write resp");
		rd_reg(5'h10);
		chk({rd[29:0], rsp}, {30'h0000_0000, crcg_pkg::RESP_DECERR}, "unmapped read");
	endtask : s_reset

	task automatic s_crc(input logic [3:0] pl, input logic [15:0] tp, input int n);
		logic [15:0] exp;
		logic [31:0] d;
		logic [3:0]  s;
		int          e0;
		exp = 16'h0000;
		s = (pl > 4'h7) ? 4'h3 : 4'h1;
		wr(A_TAP, 32'(tp), 4'h3);
		wr(A_DAT, 32'h0000_0000, 4'h3);
		wr(A_CTL, 32'(pl), 4'h3);
		for (int i = 0; i < n; i++) begin
			d = 32'h0000_A5C3 ^ (i * 32'h0000_1357);
			if (s == 4'h3 && i == 0) begin
				// split element: the low byte must come from the earlier byte write, not this one
				wr(A_WDT, d, 4'h1);
				wr(A_WDT, d ^ 32'h0000_00FF, 4'h2);
			end else begin
				wr(A_WDT, d, s);
			end
			exp = crc_step(exp, (pl > 4'h7) ? d[15:0] : {8'h00, d[7:0]}, pl, tp);
		end
		rd_reg(A_CTL);
		chk(rd, 32'(pl) | (32'(n) << 8), "count after pushes");
		e0 = ev_cnt;
		wr(A_CTL, GO | 32'(pl), 4'h3);
		wait_ev(e0);
		n_checks++;
		if (ev_cyc - t_b < (int'(pl) + 1) * n - 1 || ev_cyc - t_b > (int'(pl) + 1) * n + 3) begin
			error_cnt++;
			$display("FAIL %0t drain took %0d cycles", $time, ev_cyc - t_b);
		end
		rd_reg(A_CTL);
		chk(rd, GO | 32'h0000_0040 | 32'(pl), "empty after drain");
		rd_reg(A_WDT);
		chk(rd, 32'(exp), "crc result");
		wr(A_CTL, 32'(pl), 4'h3);
	endtask : s_crc

	task automatic s_full(input logic [3:0] pl, input int depth);
		int e0;
		wr(A_CTL, 32'(pl), 4'h3);
		for (int i = 0; i < depth; i++) wr(A_WDT, 32'h0000_3C00 + i, 4'h3);
		rd_reg(A_CTL);
		chk(rd, 32'h0000_0080 | (32'(depth) << 8) | 32'(pl), "full at depth");
		e0 = ev_cnt;
		wr(A_WDT, 32'h0000_0055, 4'h3);
		rd_reg(A_CTL);
		chk(rd, 32'h0000_0040 | 32'(pl), "wrap to empty");
		chk(32'(ev_cnt), 32'(e0), "no event on wrap");
		wr(A_CTL, 32'h0000_1FC0 | 32'(pl), 4'h3);
		rd_reg(A_CTL);
		chk(rd, 32'h0000_0040 | 32'(pl), "status bits read-only");
	endtask : s_full

	task automatic s_freeze();
		logic [15:0] exp;
		logic [31:0] c1;
		logic [31:0] k1;
		int          e0;
		exp = 16'h0000;
		wr(A_TAP, 32'h0000_0006, 4'h3);
		wr(A_DAT, 32'h0000_0000, 4'h3);
		wr(A_CTL, 32'h0000_0007, 4'h3);
		for (int i = 0; i < 6; i++) begin
			wr(A_WDT, 32'h0000_0091 + 32'(i * 7), 4'h1);
			exp = crc_step(exp, 16'(8'h91 + i * 7), 4'h7, 16'h0006);
		end
		e0 = ev_cnt;
		wr(A_CTL, GO | 32'h0000_0007, 4'h3);
		wr(A_CTL, 32'h0000_0007, 4'h3);
		rd_reg(A_CTL);
		c1 = rd;
		rd_reg(A_WDT);
		k1 = rd;
		repeat (30) @(posedge clk);
		rd_reg(A_CTL);
		chk(rd, c1, "halt keeps count");
		rd_reg(A_WDT);
		chk(rd, k1, "halt keeps crc");
		wr(A_CTL, GO | 32'h0000_0007, 4'h3);
		sleep_req <= 1'b1;
		rd_reg(A_CTL);
		c1 = rd;
		repeat (30) @(posedge clk);
		rd_reg(A_CTL);
		chk(rd, c1, "sleep freezes");
		sleep_req <= 1'b0;
		idle_req <= 1'b1;
		rd_reg(A_CTL);
		c1 = rd;
		repeat (20) @(posedge clk);
		rd_reg(A_CTL);
		n_checks++;
		if (rd[12:8] === c1[12:8]) begin
			error_cnt++;
			$display("FAIL %0t idle without stop bit halted", $time);
		end
		wr(A_CTL, IDLE | GO | 32'h0000_0007, 4'h3);
		rd_reg(A_CTL);
		c1 = rd;
		repeat (20) @(posedge clk);
		rd_reg(A_CTL);
		chk(rd, c1, "idle with stop bit freezes");
		idle_req <= 1'b0;
		wait_ev(e0);
		rd_reg(A_DAT);
		chk(rd, 32'(exp), "crc after resume");
		wr(A_CTL, 32'h0000_0007, 4'h3);
	endtask : s_freeze

	// ----------------------------------------------------------------
	// run control
	// ----------------------------------------------------------------
	task automatic complete_run();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run

	initial begin
		#(40000 * 100);
		error_cnt++;
		$display("FAIL %0t watchdog expired", $time);
		complete_run();
	end

	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		s_reset();
		s_crc(4'h7, 16'h0006, 5);
		s_crc(4'hF, 16'h1020, 3);
		s_full(4'h7, 16);
		s_full(4'hF, 8);
		s_freeze();
		complete_run();
	end

endmodule : tb_top

`default_nettype wire
